// ### hw/snpk_packer.sv
// Numeric sample packer: pads samples to lanes and drives wide and narrow streams.
//
// How it works
// - Each unit sits in a byte-rounded lane.
// - Stream data width is whole bytes.
// - All values share one unit width.
// - Real takes one unit, complex two, real first.
// - Unsigned padding bits are driven zero.
// - Signed padding bits copy the sign bit.
// - Units fill lanes first, then later transfers.
// - Only complete units get padded to bytes.
// - Unpacketized scalars keep the last flag low.
// - Unit-length vectors raise last every value.
// - Narrow complex: real transfer, then imaginary transfer.
// - Wide complex: both parts in one transfer.
// - Wide-to-narrow split keeps unit order.
// - Identifier at most 8, destination 4 bits.
// - User width a multiple of data bytes.
`timescale 1ns/1ps
`default_nettype none
module snpk_packer
    import snpk_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic cfg_signed,
    input wire logic cfg_complex,
    input wire logic cfg_unit_last,
    input wire logic cfg_narrow,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [SNPK_UNIT_W-1:0] s_re,
    input wire logic [SNPK_UNIT_W-1:0] s_im,
    output logic m_w_tvalid,
    input wire logic m_w_tready,
    output logic [SNPK_WIDE_W-1:0] m_w_tdata,
    output logic m_w_tlast,
    output logic m_n_tvalid,
    input wire logic m_n_tready,
    output logic [SNPK_NARROW_W-1:0] m_n_tdata,
    output logic m_n_tlast
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    snpk_main_st_t st_r; // Registered state of the block outside the buffer.
    snpk_main_st_t st_nxt; // Next state.
    logic [SNPK_LANES-1:0][SNPK_UNIT_W-1:0] units; // Raw units, real in slot 0.
    logic [SNPK_LANES-1:0][SNPK_LANE_W-1:0] lanes; // Padded lanes.
    logic f_in_valid; // Packed word offered to the buffer.
    logic f_in_ready; // Buffer has room.
    logic [SNPK_FIFO_W-1:0] f_in_data; // Packed word with flags.
    logic f_out_valid; // Buffer head is valid.
    logic f_out_ready; // An output stage takes the head.
    logic [SNPK_FIFO_W-1:0] f_out_data; // Buffer head.
    logic n_free; // Narrow output register may load this cycle.

    // ------------------------------------------------------------------
    // Lane padding
    // ------------------------------------------------------------------
    // The real part always occupies the first slot, the imaginary the second.
    assign units = {s_im, s_re};

    // Both lanes go through the same padder, so every value shares one width.
    genvar g;
    for (g = 0; g < SNPK_LANES; g++) begin : g_pad
        snpk_pad u_pad (
            .unit(units[g]),
            .is_signed(cfg_signed),
            .lane(lanes[g])
        );
    end

    // ------------------------------------------------------------------
    // Buffer
    // ------------------------------------------------------------------
    // The buffer decouples sample intake from output back-pressure.
    snpk_fifo #(
        .W(SNPK_FIFO_W),
        .DEPTH(SNPK_FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Packing on the intake side, then the two output registers.
    always_comb begin
        st_nxt = st_r;
        f_in_valid = 1'b0;
        f_in_data = '0;
        s_ready = 1'b0;
        f_out_ready = 1'b0;
        n_free = !st_r.nv || m_n_tready;

        // Intake: build one buffer word per complex value, real pair or unit-last real.
        if (cfg_complex) begin
            // Both parts of a complex value travel in one wide word.
            f_in_data = {cfg_unit_last, 1'b1, lanes[1], lanes[0]};
            f_in_valid = s_valid;
            s_ready = f_in_ready;
        end else if (cfg_unit_last) begin
            // Each real is its own packet, so it rides alone in lane 0.
            f_in_data = {1'b1, 1'b0, {SNPK_LANE_W{1'b0}}, lanes[0]};
            f_in_valid = s_valid;
            s_ready = f_in_ready;
        end else if (!st_r.pend) begin
            // The first real of a pair waits for a partner.
            s_ready = 1'b1;
            if (s_valid) begin
                st_nxt.pend = 1'b1;
                st_nxt.pend_d = lanes[0];
            end
        end else begin
            // The earlier real goes to the lower lane, the later above it.
            f_in_data = {1'b0, 1'b1, lanes[0], st_r.pend_d};
            f_in_valid = s_valid;
            s_ready = f_in_ready;
            if (s_valid && f_in_ready) begin
                st_nxt.pend = 1'b0;
            end
        end

        // Wide output: a taken word frees the register.
        if (st_r.wv && m_w_tready) begin
            st_nxt.wv = 1'b0;
        end
        // The register only reloads once empty or taken, so data stays put.
        if (!cfg_narrow) begin
            f_out_ready = !st_r.wv || m_w_tready;
            if (f_out_valid && f_out_ready) begin
                st_nxt.wv = 1'b1;
                st_nxt.wd = f_out_data[SNPK_WIDE_W-1:0];
                st_nxt.wl = f_out_data[SNPK_FW_LAST];
            end
        end

        // Narrow output: a taken lane frees the register.
        if (st_r.nv && m_n_tready) begin
            st_nxt.nv = 1'b0;
        end
        case (st_r.nar)
            SNPK_NAR_LO: begin
                // Lower lane goes first; a second unit is parked for later.
                if (cfg_narrow) begin
                    f_out_ready = n_free;
                    if (f_out_valid && n_free) begin
                        st_nxt.nv = 1'b1;
                        st_nxt.nd = f_out_data[SNPK_LANE_W-1:0];
                        if (f_out_data[SNPK_FW_PAIR]) begin
                            st_nxt.nl = 1'b0;
                            st_nxt.hi = f_out_data[SNPK_WIDE_W-1:SNPK_LANE_W];
                            st_nxt.hil = f_out_data[SNPK_FW_LAST];
                            st_nxt.nar = SNPK_NAR_HI;
                        end else begin
                            st_nxt.nl = f_out_data[SNPK_FW_LAST];
                        end
                    end
                end
            end
            SNPK_NAR_HI: begin
                // Upper lane follows; a complex value closes on its imaginary part.
                if (n_free) begin
                    st_nxt.nv = 1'b1;
                    st_nxt.nd = st_r.hi;
                    st_nxt.nl = st_r.hil;
                    st_nxt.nar = SNPK_NAR_LO;
                end
            end
            default: begin
                st_nxt.nar = SNPK_NAR_LO;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= SNPK_MAIN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Every data output comes straight from a register.
    assign m_w_tvalid = st_r.wv;
    assign m_w_tdata = st_r.wd;
    assign m_w_tlast = st_r.wl;
    assign m_n_tvalid = st_r.nv;
    assign m_n_tdata = st_r.nd;
    assign m_n_tlast = st_r.nl;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    // A real taken with no partner waiting, in pairing mode.
    logic first_take;
    assign first_take = s_valid && s_ready && !cfg_complex && !cfg_unit_last && !st_r.pend;

    // The lower narrow lane of a pair leaves the register.
    sequence seq_lo_sent;
        st_r.nv && m_n_tready && (st_r.nar == SNPK_NAR_HI);
    endsequence

    // The parked upper lane then appears on the narrow port.
    sequence seq_hi_shown(logic [SNPK_LANE_W-1:0] h, logic hl);
        m_n_tvalid && (m_n_tdata == h) && (m_n_tlast == hl);
    endsequence

    // A stalled beat must stay unchanged on the next cycle.
    sequence seq_w_stall;
        m_w_tvalid && !m_w_tready;
    endsequence

    AST_LANE_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (SNPK_LANE_W % 8 == 0) && (SNPK_LANE_W >= SNPK_UNIT_W) && (SNPK_LANE_W - SNPK_UNIT_W < 8))
        else $error("Lane width is not the unit rounded up to bytes.");

    AST_TDATA_BYTES: assert property (@(posedge sys_clk) disable iff (!rst_n)
        ($bits(m_w_tdata) % 8 == 0) && ($bits(m_n_tdata) % 8 == 0))
        else $error("Stream data width is not a whole number of bytes.");

    AST_SAME_WIDTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        s_valid |-> (lanes[0][SNPK_UNIT_W-1:0] == s_re) && (lanes[1][SNPK_UNIT_W-1:0] == s_im))
        else $error("A lane does not carry its unit at the common width.");

    AST_COMPLEX_ORDER: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (f_in_valid && cfg_complex) |-> (f_in_data[SNPK_LANE_W-1:0] == lanes[0]) && f_in_data[SNPK_FW_PAIR])
        else $error("Complex word does not hold the real part in the lower lane.");

    AST_ZERO_PAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_valid && !cfg_signed) |-> (lanes[0][SNPK_LANE_W-1:SNPK_UNIT_W] == '0))
        else $error("Unsigned padding is not zero.");

    AST_SIGN_PAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (s_valid && cfg_signed) |-> (lanes[1][SNPK_LANE_W-1:SNPK_UNIT_W] == {SNPK_PAD_W{s_im[SNPK_UNIT_W-1]}}))
        else $error("Signed padding does not copy the sign bit.");

    AST_SPATIAL_FIRST: assert property (@(posedge sys_clk) disable iff (!rst_n)
        first_take |=> st_r.pend && (st_r.pend_d == $past(lanes[0])))
        else $error("First real of a pair was not kept for the lower lane.");

    AST_NO_LAST: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!cfg_unit_last && m_w_tvalid) |-> !m_w_tlast)
        else $error("Last raised on an unpacketized wide stream.");

    AST_UNIT_LAST: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (f_in_valid && cfg_unit_last) |-> f_in_data[SNPK_FW_LAST])
        else $error("A unit-length vector was packed without last.");

    AST_NARROW_SPLIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_lo_sent |=> seq_hi_shown($past(st_r.hi), $past(st_r.hil)))
        else $error("Upper lane did not follow the lower lane on the narrow port.");

    AST_WIDE_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_w_stall |=> m_w_tvalid && $stable(m_w_tdata) && $stable(m_w_tlast))
        else $error("Wide beat changed while stalled.");

    AST_NARROW_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (m_n_tvalid && !m_n_tready) |=> m_n_tvalid && $stable(m_n_tdata) && $stable(m_n_tlast))
        else $error("Narrow beat changed while stalled.");

    AST_SIDE_FIELDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (SNPK_ID_W <= SNPK_ID_W_MAX) && (SNPK_DEST_W <= SNPK_DEST_W_MAX)
        && (SNPK_USER_W % (SNPK_WIDE_W / 8) == 0))
        else $error("Optional stream field widths are out of the advised range.");

endmodule
`default_nettype wire

// ### hw/snpk_pkg.sv
// Shared constants and types of the numeric sample packer.
package snpk_pkg;

    // ------------------------------------------------------------------
    // Sample and lane geometry
    // ------------------------------------------------------------------
    // Width of one fixed-point base unit, the same for every value of the stream.
    localparam int SNPK_UNIT_W = 12;
    // One lane is the base unit rounded up to whole bytes.
    localparam int SNPK_LANE_W = ((SNPK_UNIT_W + 7) / 8) * 8;
    // Padding bits that sit above each base unit.
    localparam int SNPK_PAD_W = SNPK_LANE_W - SNPK_UNIT_W;
    // Lanes carried side by side on the wide output.
    localparam int SNPK_LANES = 2;
    // Wide output data width: two padded lanes.
    localparam int SNPK_WIDE_W = SNPK_LANES * SNPK_LANE_W;
    // Narrow output data width: a single padded lane.
    localparam int SNPK_NARROW_W = SNPK_LANE_W;

    // ------------------------------------------------------------------
    // Optional stream fields
    // ------------------------------------------------------------------
    // The block drives no identifier, destination or user sideband.
    localparam int SNPK_ID_W = 0;
    localparam int SNPK_DEST_W = 0;
    localparam int SNPK_USER_W = 0;
    // Largest advisable identifier and destination widths.
    localparam int SNPK_ID_W_MAX = 8;
    localparam int SNPK_DEST_W_MAX = 4;

    // ------------------------------------------------------------------
    // Word buffer between packer and output stages
    // ------------------------------------------------------------------
    localparam int SNPK_FIFO_DEPTH = 8;
    // Buffer word: data, then a two-unit flag, then the last flag on top.
    localparam int SNPK_FW_PAIR = SNPK_WIDE_W;
    localparam int SNPK_FW_LAST = SNPK_WIDE_W + 1;
    localparam int SNPK_FIFO_W = SNPK_WIDE_W + 2;

    // ------------------------------------------------------------------
    // Narrow output sequencer
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SNPK_NAR_LO = 2'b01,
        SNPK_NAR_HI = 2'b10
    } snpk_nar_t;

    // Whole state of the packer top.
    typedef struct packed {
        logic pend;
        logic [SNPK_LANE_W-1:0] pend_d;
        logic wv;
        logic [SNPK_WIDE_W-1:0] wd;
        logic wl;
        logic nv;
        logic [SNPK_LANE_W-1:0] nd;
        logic nl;
        snpk_nar_t nar;
        logic [SNPK_LANE_W-1:0] hi;
        logic hil;
    } snpk_main_st_t;

    // Value of the packer state after reset.
    localparam snpk_main_st_t SNPK_MAIN_RST = '{
        pend: 1'b0, pend_d: '0, wv: 1'b0, wd: '0, wl: 1'b0, nv: 1'b0,
        nd: '0, nl: 1'b0, nar: SNPK_NAR_LO, hi: '0, hil: 1'b0};

endpackage

// ### hw/snpk_pad.sv
// Pads one base unit to a byte-aligned lane with sign or zero extension.
`timescale 1ns/1ps
`default_nettype none
module snpk_pad
    import snpk_pkg::*;
(
    input wire logic [SNPK_UNIT_W-1:0] unit,
    input wire logic is_signed,
    output logic [SNPK_LANE_W-1:0] lane
);

    // ------------------------------------------------------------------
    // Extension
    // ------------------------------------------------------------------
    // The unit arrives whole, so only a complete value is ever padded.
    // Signed units copy their top bit upward, unsigned units get zeros.
    assign lane = {{SNPK_PAD_W{is_signed & unit[SNPK_UNIT_W-1]}}, unit};

endmodule
`default_nettype wire

// ### hw/snpk_fifo.sv
// Word FIFO with a registered read port and valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module snpk_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    // Depth must be a power of two so the pointers wrap by themselves.
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [W-1:0] od;
    } snpk_fifo_st_t;

    snpk_fifo_st_t st_r; // Registered state.
    snpk_fifo_st_t st_nxt; // Next state.
    logic push; // A word enters this cycle.
    logic load; // The read register takes a new word or empties.

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Full is honest: the storage refuses a word once all entries hold data.
    always_comb begin
        st_nxt = st_r;
        in_ready = (st_r.cnt != (AW+1)'(DEPTH));
        push = in_valid && in_ready;
        load = !st_r.ov || out_ready;
        // A new word is written at the write pointer.
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data;
            st_nxt.wp = st_r.wp + AW'(1);
        end
        // The read register refills from storage whenever it drains.
        if (load) begin
            if (st_r.cnt != '0) begin
                st_nxt.od = st_r.mem[st_r.rp];
                st_nxt.rp = st_r.rp + AW'(1);
                st_nxt.ov = 1'b1;
            end else begin
                st_nxt.ov = 1'b0;
            end
        end
        // Count entries still in storage.
        if (push && !(load && st_r.cnt != '0)) begin
            st_nxt.cnt = st_r.cnt + (AW+1)'(1);
        end else if (!push && load && st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - (AW+1)'(1);
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign out_valid = st_r.ov;
    assign out_data = st_r.od;

endmodule
`default_nettype wire

// ### verification/snpk_sink.sv
// Downstream stream slave model that takes beats and watches that stalled beats are held.
`timescale 1ns/1ps
`default_nettype none
module snpk_sink #(
    parameter int W = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic stall,
    input wire logic tvalid,
    output logic tready,
    input wire logic [W-1:0] tdata,
    input wire logic tlast,
    output logic got,
    output logic [W:0] beat,
    output logic hold_err
);
    // ------------------------------------------------------------------
    // Acceptance
    // ------------------------------------------------------------------
    logic wait_r; // A beat was offered and refused at the last edge.
    logic [W:0] held_r; // The beat that was refused.

    // The slave is slow only when told to be, so every stall is a stall the bench meant.
    assign tready = ~stall;

    // A beat counts only at an edge with valid and ready both high.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            got <= 1'b0;
            beat <= '0;
            hold_err <= 1'b0;
            wait_r <= 1'b0;
            held_r <= '0;
        end else begin
            got <= tvalid & tready;
            // The whole lane is kept as seen; padding bits are not interpreted here.
            beat <= {tlast, tdata};
            wait_r <= tvalid & ~tready;
            held_r <= {tlast, tdata};
            hold_err <= wait_r & (~tvalid | ({tlast, tdata} !== held_r));
        end
    end
endmodule
`default_nettype wire

// ### verification/snpk_packer_tb_top.sv
// Self-checking testbench of the numeric sample packer.
`timescale 1ns/1ps
`default_nettype none
module snpk_packer_tb_top
    import snpk_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic sys_clk = 1'b0, rst_n = 1'b0, s_valid = 1'b0;
    logic cfg_signed = 1'b0, cfg_complex = 1'b0, cfg_unit_last = 1'b0, cfg_narrow = 1'b0;
    logic [SNPK_UNIT_W-1:0] s_re = '0, s_im = '0;
    logic s_ready, m_w_tvalid, m_w_tready, m_w_tlast, m_n_tvalid, m_n_tready, m_n_tlast;
    logic [SNPK_WIDE_W-1:0] m_w_tdata;
    logic [SNPK_NARROW_W-1:0] m_n_tdata;
    logic slow = 1'b0, hold = 1'b0, stall = 1'b0; // Back-pressure controls of both sinks.
    logic w_got, n_got, w_herr, n_herr;
    logic [SNPK_WIDE_W:0] w_beat;
    logic [SNPK_NARROW_W:0] n_beat;
    logic [SNPK_WIDE_W:0] ew[$]; // Expected wide beats, tlast on top.
    logic [SNPK_NARROW_W:0] en[$]; // Expected narrow beats, tlast on top.
    // Sign bits set and clear on purpose, so wrong padding always shows.
    logic [SNPK_UNIT_W-1:0] ut[8] = '{12'h8a5, 12'h35c, 12'hf00, 12'h001, 12'h7ff, 12'h800, 12'hfff, 12'h0c3};
    int n_fail = 0, n_compared = 0, cyc = 0;

    snpk_packer DUT (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_signed(cfg_signed), .cfg_complex(cfg_complex),
        .cfg_unit_last(cfg_unit_last), .cfg_narrow(cfg_narrow), .s_valid(s_valid), .s_ready(s_ready),
        .s_re(s_re), .s_im(s_im), .m_w_tvalid(m_w_tvalid), .m_w_tready(m_w_tready), .m_w_tdata(m_w_tdata),
        .m_w_tlast(m_w_tlast), .m_n_tvalid(m_n_tvalid), .m_n_tready(m_n_tready), .m_n_tdata(m_n_tdata),
        .m_n_tlast(m_n_tlast));
    snpk_sink #(.W(SNPK_WIDE_W)) sink_w (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall), .tvalid(m_w_tvalid),
        .tready(m_w_tready), .tdata(m_w_tdata), .tlast(m_w_tlast), .got(w_got), .beat(w_beat), .hold_err(w_herr));
    snpk_sink #(.W(SNPK_NARROW_W)) sink_n (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall), .tvalid(m_n_tvalid),
        .tready(m_n_tready), .tdata(m_n_tdata), .tlast(m_n_tlast), .got(n_got), .beat(n_beat), .hold_err(n_herr));

    // ------------------------------------------------------------------
    // Clock, stall pattern, timeout
    // ------------------------------------------------------------------
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end

    // A slow sink refuses every other cycle; hold refuses until released.
    always @(posedge sys_clk) begin
        stall <= hold | (slow & ~stall);
        cyc++;
        if (cyc == 20000) begin
            report("run did not finish in time");
            test_done();
        end
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic report(input string msg);
        n_fail++;
        $display("[ERR] %0t %s", $time, msg);
    endtask

    // Expected lane of one unit under the current signedness.
    function automatic logic [SNPK_LANE_W-1:0] lane(input logic [SNPK_UNIT_W-1:0] u);
        lane = cfg_signed ? {{SNPK_PAD_W{u[SNPK_UNIT_W-1]}}, u} : {{SNPK_PAD_W{1'b0}}, u};
    endfunction

    // Queues one word on the port in use; narrow splits it lane 0 first.
    task automatic expect_word(input logic [SNPK_LANE_W-1:0] l0, l1, input logic two, last);
        if (cfg_narrow) begin
            if (two) begin
                en.push_back({1'b0, l0});
                en.push_back({last, l1});
            end else begin
                en.push_back({last, l0});
            end
        end else begin
            ew.push_back({last, l1, l0});
        end
    endtask

    // Offers one sample and returns at the edge that takes it; valid stays up.
    task automatic send(input logic [SNPK_UNIT_W-1:0] re, im);
        s_valid <= 1'b1;
        s_re <= re;
        s_im <= im;
        @(negedge sys_clk);
        while (s_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
    endtask

    // Waits a bounded time for all expected beats, then reports the test.
    task automatic settle(input string what);
        int k;
        k = 0;
        while (ew.size() + en.size() != 0 && k < 300) begin
            @(posedge sys_clk);
            k++;
        end
        if (k == 300) report("expected beats never arrived");
        repeat (4) @(posedge sys_clk);
        $display("%s finished, mismatches so far %0d", what, n_fail);
    endtask

    // Every taken beat must match the front of its queue; a stray beat is an error.
    always @(negedge sys_clk) begin
        if (w_got === 1'b1) begin
            n_compared++;
            if (ew.size() == 0 || w_beat !== ew.pop_front()) report("wide beat wrong");
        end
        if (n_got === 1'b1) begin
            n_compared++;
            if (en.size() == 0 || n_beat !== en.pop_front()) report("narrow beat wrong");
        end
        if (w_herr === 1'b1 || n_herr === 1'b1) report("stalled beat not held");
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Mode bits: 0 signed, 1 complex, 2 unit last, 3 narrow, 4 slow sink.
    task automatic run_mode(input int m);
        logic [SNPK_LANE_W-1:0] prev;
        prev = '0;
        cfg_signed <= m[0];
        cfg_complex <= m[1];
        cfg_unit_last <= m[2];
        cfg_narrow <= m[3];
        slow <= m[4];
        @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            send(ut[2*i], ut[2*i+1]);
            if (m[1]) begin
                expect_word(lane(ut[2*i]), lane(ut[2*i+1]), 1'b1, m[2]);
            end else if (m[2]) begin
                expect_word(lane(ut[2*i]), '0, 1'b0, 1'b1);
            end else if (i % 2 == 1) begin
                expect_word(prev, lane(ut[2*i]), 1'b1, 1'b0);
            end
            prev = lane(ut[2*i]);
        end
        s_valid <= 1'b0;
        settle($sformatf("mode %0d", m));
    endtask

    // Fills the buffer against a stalled sink until it refuses, then drains slowly.
    task automatic fill_drain();
        int acc, lowc;
        acc = 0;
        lowc = 0;
        cfg_signed <= 1'b1;
        cfg_complex <= 1'b1;
        cfg_unit_last <= 1'b0;
        cfg_narrow <= 1'b0;
        slow <= 1'b0;
        hold <= 1'b1;
        @(posedge sys_clk);
        s_valid <= 1'b1;
        while (lowc < 8 && acc < 20) begin
            s_re <= ut[acc%8];
            s_im <= ut[(acc+3)%8];
            @(negedge sys_clk);
            if (s_ready === 1'b1) begin
                expect_word(lane(ut[acc%8]), lane(ut[(acc+3)%8]), 1'b1, 1'b0);
                acc++;
            end else begin
                lowc++;
            end
            @(posedge sys_clk);
        end
        s_valid <= 1'b0;
        hold <= 1'b0;
        slow <= 1'b1;
        n_compared++;
        // Storage, read register and output register hold exactly depth plus two words.
        if (lowc != 8 || acc != SNPK_FIFO_DEPTH + 2) report("buffer did not fill and refuse");
        settle("fill and drain");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and verdict
    // ------------------------------------------------------------------
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int m = 0; m < 32; m++) run_mode(m);
        fill_drain();
        test_done();
    end
endmodule
`default_nettype wire
